// ### vsbd_defs.vh
/*
 * Constants for the serial byte decoder of the 16-position display:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 40 MHz pclk and 32-bit APB data with byte addresses.
 */
`ifndef VSBD_DEFS_VH
`define VSBD_DEFS_VH

// register byte offsets
`define VSBD_OFS_CTRL      8'h00
`define VSBD_OFS_STAT      8'h04
`define VSBD_OFS_DISP      8'h08
`define VSBD_OFS_BUF       8'h40

// control register fields
`define VSBD_CTRL_HOLD     0

// status register fields
`define VSBD_STAT_PTR_LSB  0
`define VSBD_STAT_LVL_LSB  4
`define VSBD_STAT_OVF      16
`define VSBD_STAT_INIT     17

// display register fields
`define VSBD_DISP_DUTY_LSB 0
`define VSBD_DISP_CNT_LSB  8

// received byte layout
`define VSBD_CMD_BIT       7
`define VSBD_OP_PTR        4'hA
`define VSBD_OP_CNT        4'hC
`define VSBD_OP_DUTY       3'h7

// buffer entry layout: code, point flag, comma flag
`define VSBD_ENT_DP        6
`define VSBD_ENT_COMMA     7

// character codes that attach to the previous character
`define VSBD_CODE_DP       6'h2E
`define VSBD_CODE_COMMA    6'h2C

// values after reset or initialisation
`define VSBD_DUTY_RST      5'h00
`define VSBD_CNT_RST       5'h10
`define VSBD_PTR_RST       4'hF

// timing: least initialisation pulse the host must give
`define VSBD_CLK_NS        25
`define VSBD_TRST_NS       100000
`define VSBD_TRST_CYC      ((`VSBD_TRST_NS + `VSBD_CLK_NS - 1) / `VSBD_CLK_NS)

// fifo shape
`define VSBD_FIFO_W        8
`define VSBD_FIFO_D        32

`endif

// ### vsbd_fifo.v
/*
 * Synchronous FIFO with valid/ready on both sides and a clear input.
 * Assumes one clock; depth is a power of two.
 */
`timescale 1ns/1ps
module vsbd_fifo #(
    parameter W  = 8,
    parameter D  = 32,
    parameter AW = 5
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          clr,
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data,
    output wire [AW:0]   level
);
    reg  [W-1:0]  mem [0:D-1];
    reg  [AW-1:0] wr_q;
    reg  [AW-1:0] rd_q;
    reg  [AW:0]   cnt_q;
    wire          push;
    wire          pop;

    // honest flags straight from the occupancy count
    assign in_ready  = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_q];
    assign level     = cnt_q;

    // storage has no reset; only pointers matter
    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // pointers and count
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (clr) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // vsbd_fifo

// ### vsbd_top.v
/*
 * Serial byte decoder for a 16-position alphanumeric display.
 * Captures bytes from the shift clock and data pins, queues them in a
 * FIFO and decodes control and character bytes into pointer, digit
 * count, duty and a 16-entry display buffer, all readable over APB.
 * Assumes the pins are asynchronous to pclk and that the shift clock
 * half periods span several pclk cycles.
 */
// The APB slave port and the register offsets were decided locally.
// Notes on behaviour
// - eight bits, MSB first, on falling clock
// - first bit is the command flag
// - flag one means control byte
// - opcode 1010 loads buffer pointer
// - AF is position one, AE sixteen
// - opcode 1100 loads digit counter
// - opcode 111 loads five-bit duty
// - duty sets on-time in 1/32 steps
// - duty zero blanks the display
// - flag zero: six-bit character code
// - pointer advances before each character store
// - points and commas do not advance
// - init: duty 0, sixteen digits, position one
`timescale 1ns/1ps
`include "vsbd_defs.vh"
module vsbd_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        sclk_pin,
    input  wire        sdata_pin,
    input  wire        init_n_pin,
    output wire [4:0]  lum_duty,
    output wire [4:0]  digit_count,
    output wire        display_blank
);
    localparam S_IDLE = 2'b01;
    localparam S_SHIFT = 2'b10;

    // pin synchronisers
    reg  [2:0]   sclk_s_q;
    reg  [1:0]   sdata_s_q;
    reg  [1:0]   init_s_q;
    wire         sclk_fall;
    wire         init_act;

    // link capture
    reg  [1:0]   lstate_q;
    reg  [2:0]   bitcnt_q;
    reg  [6:0]   shift_q;
    reg          push_q;
    reg  [7:0]   byte_q;

    // fifo
    wire         fifo_iready;
    wire         fifo_ovalid;
    wire         fifo_oready;
    wire [7:0]   fifo_odata;
    wire [5:0]   fifo_level;

    // decoder state
    reg  [3:0]   ptr_q;
    reg  [3:0]   ptr_d;
    reg  [4:0]   duty_q;
    reg  [4:0]   duty_d;
    reg  [4:0]   cnt_q;
    reg  [4:0]   cnt_d;
    reg          wr_en;
    reg          wr_attach;
    reg  [3:0]   wr_idx;
    reg  [7:0]   wr_ent;
    wire         take;
    wire [7:0]   rx;
    reg  [127:0] buf_q;

    // software registers
    reg          hold_q;
    reg          ovf_q;
    reg  [31:0]  rdata_q;
    reg          err_q;
    reg  [31:0]  rd_mux;
    reg          rd_err;
    wire         wr_acc;
    wire         setup;

    // two flops per pin; the third sclk flop only feeds edge detection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_s_q  <= 3'h7;
            sdata_s_q <= 2'h0;
            init_s_q  <= 2'h3;
        end else begin
            sclk_s_q  <= {sclk_s_q[1:0], sclk_pin};
            sdata_s_q <= {sdata_s_q[0], sdata_pin};
            init_s_q  <= {init_s_q[0], init_n_pin};
        end
    end

    assign sclk_fall = sclk_s_q[2] & ~sclk_s_q[1];
    assign init_act  = ~init_s_q[1];

    // shift in MSB first; the eighth falling edge completes the byte
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lstate_q <= S_IDLE;
            bitcnt_q <= 3'h0;
            shift_q  <= 7'h00;
            push_q   <= 1'b0;
            byte_q   <= 8'h00;
        end else if (init_act) begin
            lstate_q <= S_IDLE;
            bitcnt_q <= 3'h0;
            push_q   <= 1'b0;
        end else begin
            push_q <= 1'b0;
            case (lstate_q)
                S_IDLE: begin
                    if (sclk_fall) begin
                        // first bit is the command flag
                        shift_q  <= {6'h00, sdata_s_q[1]};
                        bitcnt_q <= 3'h1;
                        lstate_q <= S_SHIFT;
                    end
                end
                S_SHIFT: begin
                    if (sclk_fall) begin
                        if (bitcnt_q == 3'h7) begin
                            byte_q   <= {shift_q, sdata_s_q[1]};
                            push_q   <= 1'b1;
                            bitcnt_q <= 3'h0;
                            lstate_q <= S_IDLE;
                        end else begin
                            shift_q  <= {shift_q[5:0], sdata_s_q[1]};
                            bitcnt_q <= bitcnt_q + 3'h1;
                        end
                    end
                end
                default: begin
                    lstate_q <= S_IDLE;
                    bitcnt_q <= 3'h0;
                end
            endcase
        end
    end

    // the serial host cannot be stalled, so a full queue drops the byte
    vsbd_fifo #(
        .W  (`VSBD_FIFO_W),
        .D  (`VSBD_FIFO_D),
        .AW (5)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .clr       (init_act),
        .in_valid  (push_q),
        .in_ready  (fifo_iready),
        .in_data   (byte_q),
        .out_valid (fifo_ovalid),
        .out_ready (fifo_oready),
        .out_data  (fifo_odata),
        .level     (fifo_level)
    );

    // software hold stalls decoding so the queue can fill
    assign fifo_oready = ~hold_q & ~init_act;
    assign take        = fifo_ovalid & fifo_oready;
    assign rx          = fifo_odata;

    // byte decode
    always @* begin
        ptr_d     = ptr_q;
        duty_d    = duty_q;
        cnt_d     = cnt_q;
        wr_en     = 1'b0;
        wr_attach = 1'b0;
        wr_idx    = ptr_q;
        wr_ent    = 8'h00;
        if (take) begin
            if (rx[`VSBD_CMD_BIT]) begin
                if (rx[7:4] == `VSBD_OP_PTR) begin
                    // raw nibble kept; next store lands one past it
                    ptr_d = rx[3:0];
                end else if (rx[7:4] == `VSBD_OP_CNT) begin
                    // zero nibble stands for all sixteen
                    cnt_d = {(rx[3:0] == 4'h0), rx[3:0]};
                end else if (rx[7:5] == `VSBD_OP_DUTY) begin
                    duty_d = rx[4:0];
                end
            end else if (rx[5:0] == `VSBD_CODE_DP ||
                         rx[5:0] == `VSBD_CODE_COMMA) begin
                // attach to the character stored last
                wr_en     = 1'b1;
                wr_attach = 1'b1;
                wr_idx    = ptr_q;
                wr_ent    = {rx[5:0] == `VSBD_CODE_COMMA,
                             rx[5:0] == `VSBD_CODE_DP, 6'h00};
            end else begin
                // bit 6 ignored; natural 4-bit wrap keeps index 0..15
                ptr_d  = ptr_q + 4'h1;
                wr_en  = 1'b1;
                wr_idx = ptr_d;
                wr_ent = {2'b00, rx[5:0]};
            end
        end
    end

    // decoder registers; init pin restores the power-on values
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q  <= `VSBD_PTR_RST;
            duty_q <= `VSBD_DUTY_RST;
            cnt_q  <= `VSBD_CNT_RST;
        end else if (init_act) begin
            ptr_q  <= `VSBD_PTR_RST;
            duty_q <= `VSBD_DUTY_RST;
            cnt_q  <= `VSBD_CNT_RST;
        end else begin
            ptr_q  <= ptr_d;
            duty_q <= duty_d;
            cnt_q  <= cnt_d;
        end
    end

    // one buffer entry per position
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_ent
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    buf_q[gi*8 +: 8] <= 8'h00;
                end else if (wr_en && wr_idx == gi) begin
                    if (wr_attach) begin
                        buf_q[gi*8 +: 8] <= buf_q[gi*8 +: 8] | wr_ent;
                    end else begin
                        buf_q[gi*8 +: 8] <= wr_ent;
                    end
                end
            end
        end
    endgenerate

    // duty drives all digits at once in 1/32 steps
    assign lum_duty      = duty_q;
    assign digit_count   = cnt_q;
    assign display_blank = (duty_q == 5'h00);

    // apb: setup cycle latches read data, access completes at once
    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pwrite;
    assign pready  = psel & penable;
    assign prdata  = rdata_q;
    assign pslverr = err_q & psel & penable;

    // read mux and address decode
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr[7:6] == 2'b01 && paddr[1:0] == 2'b00) begin
            rd_mux[7:0] = buf_q[{paddr[5:2], 3'h0} +: 8];
        end else if (paddr == `VSBD_OFS_CTRL) begin
            rd_mux[`VSBD_CTRL_HOLD] = hold_q;
        end else if (paddr == `VSBD_OFS_STAT) begin
            rd_mux[`VSBD_STAT_PTR_LSB +: 4] = ptr_q;
            rd_mux[`VSBD_STAT_LVL_LSB +: 6] = fifo_level;
            rd_mux[`VSBD_STAT_OVF]          = ovf_q;
            rd_mux[`VSBD_STAT_INIT]         = init_act;
        end else if (paddr == `VSBD_OFS_DISP) begin
            rd_mux[`VSBD_DISP_DUTY_LSB +: 5] = duty_q;
            rd_mux[`VSBD_DISP_CNT_LSB +: 5]  = cnt_q;
        end else begin
            rd_err = 1'b1;
        end
    end

    // answer registers, taken in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (setup) begin
            rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            err_q   <= rd_err;
        end
    end

    // control and sticky overflow; a drop beats a clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 1'b0;
            ovf_q  <= 1'b0;
        end else begin
            if (wr_acc && paddr == `VSBD_OFS_CTRL) begin
                hold_q <= pwdata[`VSBD_CTRL_HOLD];
            end
            if (push_q && !fifo_iready) begin
                ovf_q <= 1'b1;
            end else if (wr_acc && paddr == `VSBD_OFS_STAT &&
                         pwdata[`VSBD_STAT_OVF]) begin
                ovf_q <= 1'b0;
            end
        end
    end
endmodule // vsbd_top

// ### vsbd_host.sv
/* host partner: drives shift clock, data and init pins of the decoder.
   assumes the bench pclk; one shift clock half period is 4 pclk. */
`timescale 1ns/1ps
`include "vsbd_defs.vh"
module vsbd_host (
    input  wire  clk,
    output logic sclk_pin,
    output logic sdata_pin,
    output logic init_n_pin
);
    // idle: clock stands high between frames, init released
    initial begin
        sclk_pin = 1'b1;
        sdata_pin = 1'b0;
        init_n_pin = 1'b1;
    end
    // msb first; data changes only while the clock is high
    task send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sdata_pin <= b[i];
            repeat (4) @(posedge clk);
            sclk_pin <= 1'b0;
            repeat (4) @(posedge clk);
            sclk_pin <= 1'b1;
        end
        sdata_pin <= ~b[0]; // stale level would hide a late sample
    endtask
    // full length pulse, the decoder does not time it
    task init_pulse;
        init_n_pin <= 1'b0;
        repeat (`VSBD_TRST_CYC) @(posedge clk);
        init_n_pin <= 1'b1;
    endtask
endmodule // vsbd_host

// ### vsbd_top_assertions.sv
/* checker for the serial byte decoder top: port level relations.
   assumes it is bound into vsbd_top and sees only its ports. */
`timescale 1ns/1ps
module vsbd_top_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sclk_pin,
    input wire logic        sdata_pin,
    input wire logic        init_n_pin,
    input wire logic [4:0]  lum_duty,
    input wire logic [4:0]  digit_count,
    input wire logic        display_blank
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [5:0] idle_q;
    logic       mapped;
    // decoded address map, buffer words at 0x40..0x7C
    assign mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08 ||
                    (paddr[7:6] == 2'h1 && paddr[1:0] == 2'h0);
    // cycles with no link, init or bus activity; a hold release is an
    // apb write, so bus traffic also restarts the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            idle_q <= 6'h00;
        else if (!sclk_pin || !init_n_pin || psel)
            idle_q <= 6'h00;
        else if (idle_q != 6'h3F)
            idle_q <= idle_q + 6'h01;
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    chk_blank_duty: assert property (
        display_blank == (lum_duty == 5'h00))
        else $error("blank does not follow duty");
    chk_ready_access: assert property (s_setup ##1 s_access |-> pready)
        else $error("no ready in access cycle");
    chk_err_unmapped: assert property ((s_access and !mapped) |-> pslverr)
        else $error("unmapped access without error");
    chk_err_mapped: assert property ((s_access and mapped) |-> !pslverr)
        else $error("error on mapped access");
    chk_rdata_stands: assert property (s_access ##1 !psel |-> $stable(prdata))
        else $error("read data did not stand");
    chk_init_defaults: assert property (
        $fell(init_n_pin) |->
        ##[1:5] (lum_duty == 5'h00 && digit_count == 5'h10))
        else $error("init defaults not set");
    chk_count_range: assert property (
        digit_count != 5'h00 && digit_count <= 5'h10)
        else $error("digit count out of range");
    chk_quiet_stable: assert property (
        idle_q > 6'h28 |-> $stable(lum_duty) && $stable(digit_count))
        else $error("settings changed without a byte");
endmodule // vsbd_top_assertions

bind vsbd_top vsbd_top_assertions chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_pin(sclk_pin), .sdata_pin(sdata_pin), .init_n_pin(init_n_pin),
    .lum_duty(lum_duty), .digit_count(digit_count),
    .display_blank(display_blank));

// ### vfd_serial_byte_decoder_bench.sv
/* self-checking bench for the serial byte decoder top.
   assumes the host partner model and an apb master written here. */
`timescale 1ns/1ps
`include "vsbd_defs.vh"
module vfd_serial_byte_decoder_bench;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, sclk_pin, sdata_pin, init_n_pin;
    logic [4:0]  lum_duty, digit_count;
    logic        display_blank;
    int          n_fail = 0, checks = 0;

    vsbd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclk_pin(sclk_pin), .sdata_pin(sdata_pin), .init_n_pin(init_n_pin),
        .lum_duty(lum_duty), .digit_count(digit_count),
        .display_blank(display_blank));
    vsbd_host host (.clk(pclk), .sclk_pin(sclk_pin), .sdata_pin(sdata_pin),
        .init_n_pin(init_n_pin));

    // 40 MHz
    always #12.5 pclk = ~pclk;

    task summarize;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; waits for pready, the watchdog bounds the wait
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task sb(input logic [7:0] b);
        @(posedge pclk);
        host.send_byte(b);
        repeat (12) @(posedge pclk);
    endtask

    task t_reset;
        rchk(`VSBD_OFS_DISP, 32'h1F1F, 32'h1000);
        rchk(`VSBD_OFS_STAT, 32'hF, 32'hF);
        chk(display_blank, 1'b1);
    endtask
    task t_ctrl;
        sb(8'hF8);
        chk(lum_duty, 5'h18);
        chk(display_blank, 1'b0);
        sb(8'hFF);
        chk(lum_duty, 5'h1F);
        sb(8'hC6);
        chk(digit_count, 5'h06);
        sb(8'hC0);
        chk(digit_count, 5'h10);
        sb(8'h9F);
        chk({lum_duty, digit_count}, 10'h3F0);
        sb(8'hE0);
        chk(display_blank, 1'b1);
    endtask
    task t_chars;
        sb(8'hA5);
        sb(8'h41);
        rchk(`VSBD_OFS_BUF + 8'h18, 32'hFF, 32'h01);
        rchk(`VSBD_OFS_STAT, 32'hF, 32'h6);
        sb(8'h2E);
        sb(8'h2C);
        rchk(`VSBD_OFS_BUF + 8'h18, 32'hFF, 32'hC1);
        sb(8'hAE);
        sb(8'h13);
        sb(8'h7F);
        rchk(`VSBD_OFS_BUF + 8'h3C, 32'hFF, 32'h13);
        rchk(`VSBD_OFS_BUF, 32'hFF, 32'h3F);
    endtask
    task t_init;
        sb(8'hC6);
        sb(8'hFF);
        @(posedge pclk);
        host.init_pulse();
        repeat (4) @(posedge pclk);
        chk({lum_duty, digit_count}, 10'h010);
        sb(8'h05);
        rchk(`VSBD_OFS_BUF, 32'hFF, 32'h05);
    endtask
    // hold decoding, overfill by one, drain; the dropped byte must not land
    task t_fifo;
        apb(1'b1, `VSBD_OFS_CTRL, 32'h1);
        for (int i = 0; i < 32; i++)
            sb(8'hE0 | 8'(31 - i));
        sb(8'hE3);
        rchk(`VSBD_OFS_STAT, 32'h103F0, 32'h10200);
        apb(1'b1, `VSBD_OFS_CTRL, 32'h0);
        repeat (40) @(posedge pclk);
        chk(lum_duty, 5'h00);
        apb(1'b1, `VSBD_OFS_STAT, 32'h10000);
        rchk(`VSBD_OFS_STAT, 32'h103F0, 32'h0);
    endtask
    task t_apb;
        sb(8'hF1);
        apb(1'b1, `VSBD_OFS_DISP, 32'h0);
        chk(lum_duty, 5'h11);
        apb(1'b0, 8'h0C, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset();
        t_ctrl();
        t_chars();
        t_init();
        t_fifo();
        t_apb();
        summarize();
    end
    // watchdog well past the expected run of about 8000 cycles
    initial begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        $display("watchdog expired at %0t", $time);
        summarize();
    end
endmodule // vfd_serial_byte_decoder_bench
